// File: design/ssdp_pkg.sv
// package: register map, field positions and timing constants for the serial block
package ssdp_pkg;

	// ==========================================
	// register offsets (byte addresses)
	localparam logic [11:0] OFS_CONTROL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_DATA = 12'h008;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h00C;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
	localparam logic [11:0] OFS_VECTOR_ACK = 12'h014;

	// ==========================================
	// serial_status fields
	localparam int STAT_DONE_BIT = 7;
	localparam int STAT_WRITE_COLLISION_FLAG_BIT = 6;
	localparam int STAT_DBL_BIT = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// ==========================================
	// serial_control_reg fields
	localparam int CTL_IRQ_EN_BIT = 7;
	localparam int CTL_ENABLE_BIT = 6;
	localparam int CTL_LSB_FIRST_BIT = 5;
	localparam int CTL_MASTER_BIT = 4;
	localparam int CTL_CLOCK_POLARITY_SELECT_BIT = 3;
	localparam int CTL_CLOCK_PHASE_SELECT_BIT = 2;
	localparam int CTL_RATE_HI = 1;
	localparam int CTL_RATE_LO = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// ==========================================
	// interrupt status and mask fields
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_WRITE_COLLISION_FLAG_BIT = 1;
	localparam int IRQ_MODF_BIT = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// ==========================================
	// timing: clock rate and shift clock divisors
	localparam int PCLK_PERIOD_NS = 4;
	localparam int MIN_DBL_SCK_PERIODS = 2;
	localparam int MIN_DBL_SCK_CYCLES = MIN_DBL_SCK_PERIODS;
	localparam int DIV_BASE = 4;

	// ==========================================
	// transfer state
	typedef enum logic [1:0] {
		XS_IDLE = 2'b00,
		XS_LEAD = 2'b01,
		XS_TRAIL = 2'b10
	} ssdp_xs_t;

endpackage

// File: design/ssdp_core.sv
// serial peripheral status and data path with apb register access
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ns
module ssdp_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic global_irq_enable,
	output logic irq,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic ss_n_in
);

	// ==========================================
	// pin synchronisers
	logic [2:0] sck_sync_reg;
	logic [1:0] ss_sync_reg, mosi_sync_reg, miso_sync_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_sync_reg <= 3'h0;
			ss_sync_reg <= 2'h3;
			mosi_sync_reg <= 2'h0;
			miso_sync_reg <= 2'h0;
		end else begin
			sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
			ss_sync_reg <= {ss_sync_reg[0], ss_n_in};
			mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
			miso_sync_reg <= {miso_sync_reg[0], miso_in};
		end
	end
	logic ss_n_s, sck_s, sck_prev;
	assign ss_n_s = ss_sync_reg[1];
	assign sck_s = sck_sync_reg[1];
	assign sck_prev = sck_sync_reg[2];

	// ==========================================
	// apb decode
	logic acc, wr, rd;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign pready = 1'b1;
	logic mapped;
	assign mapped = (paddr == ssdp_pkg::OFS_CONTROL) ||
		(paddr == ssdp_pkg::OFS_STATUS) || (paddr == ssdp_pkg::OFS_DATA) ||
		(paddr == ssdp_pkg::OFS_IRQ_STATUS) ||
		(paddr == ssdp_pkg::OFS_IRQ_MASK) ||
		(paddr == ssdp_pkg::OFS_VECTOR_ACK);
	assign pslverr = acc && !mapped;
	logic data_acc, stat_rd, data_wr, ctl_wr;
	assign data_acc = acc && (paddr == ssdp_pkg::OFS_DATA);
	assign data_wr = data_acc && pwrite;
	assign stat_rd = rd && (paddr == ssdp_pkg::OFS_STATUS);
	assign ctl_wr = wr && (paddr == ssdp_pkg::OFS_CONTROL);

	// ==========================================
	// state
	logic [7:0] ctl_reg, ctl_next;
	logic done_reg, done_next, write_collision_flag_reg, write_collision_flag_next, dbl_reg, dbl_next;
	logic armed_reg, armed_next;
	logic [2:0] irqs_reg, irqs_next, mask_reg, mask_next;
	logic [7:0] shift_reg, shift_next, rxbuf_reg, rxbuf_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [6:0] div_reg, div_next;
	ssdp_pkg::ssdp_xs_t st_reg, st_next;
	logic sck_reg, sck_next, dout_reg, dout_next, sin_reg, sin_next;
	logic [31:0] prdata_reg, prdata_next;

	logic master, clock_polarity_select, clock_phase_select, lsbf, en;
	assign master = ctl_reg[ssdp_pkg::CTL_MASTER_BIT];
	assign clock_polarity_select = ctl_reg[ssdp_pkg::CTL_CLOCK_POLARITY_SELECT_BIT];
	assign clock_phase_select = ctl_reg[ssdp_pkg::CTL_CLOCK_PHASE_SELECT_BIT];
	assign lsbf = ctl_reg[ssdp_pkg::CTL_LSB_FIRST_BIT];
	assign en = ctl_reg[ssdp_pkg::CTL_ENABLE_BIT];

	// half period in pclk cycles; double speed halves it
	logic [6:0] half;
	always_comb begin
		case (ctl_reg[ssdp_pkg::CTL_RATE_HI:ssdp_pkg::CTL_RATE_LO])
			2'h0: half = 7'h02;
			2'h1: half = 7'h08;
			2'h2: half = 7'h20;
			default: half = 7'h40;
		endcase
		if (dbl_reg)
			half = half >> 1;
		if (half == 7'h00)
			half = 7'h01;
	end

	// slave edges from sampled clock
	logic s_rise, s_fall, s_lead, s_trail;
	assign s_rise = sck_s && !sck_prev;
	assign s_fall = !sck_s && sck_prev;
	assign s_lead = clock_polarity_select ? s_fall : s_rise;
	assign s_trail = clock_polarity_select ? s_rise : s_fall;
	logic slave_sel;
	assign slave_sel = en && !master && !ss_n_s;
	logic modf;
	assign modf = en && master && !ss_n_s;

	logic busy;
	assign busy = (st_reg != ssdp_pkg::XS_IDLE);
	logic in_bit, out_bit;
	assign in_bit = master ? miso_sync_reg[1] : mosi_sync_reg[1];
	assign out_bit = lsbf ? shift_reg[0] : shift_reg[7];

	logic finish;
	// ==========================================
	// transfer engine
	always_comb begin
		st_next = st_reg;
		shift_next = shift_reg;
		cnt_next = cnt_reg;
		div_next = div_reg;
		sck_next = sck_reg;
		dout_next = dout_reg;
		sin_next = sin_reg;
		rxbuf_next = rxbuf_reg;
		finish = 1'b0;
		if (!en || modf) begin
			st_next = ssdp_pkg::XS_IDLE;
			sck_next = clock_polarity_select;
		end else if (master) begin
			case (st_reg)
				ssdp_pkg::XS_IDLE: begin
					sck_next = clock_polarity_select;
					if (data_wr) begin
						shift_next = pwdata[7:0];
						cnt_next = 4'h0;
						div_next = half;
						dout_next = lsbf ? pwdata[0] : pwdata[7];
						st_next = ssdp_pkg::XS_LEAD;
					end
				end
				ssdp_pkg::XS_LEAD: begin
					if (div_reg > 7'h01) begin
						div_next = div_reg - 7'h01;
					end else begin
						div_next = half;
						sck_next = !sck_reg;
						// phase 0 samples leading; phase 1 drives it
						if (clock_phase_select)
							dout_next = out_bit;
						else
							sin_next = in_bit;
						st_next = ssdp_pkg::XS_TRAIL;
					end
				end
				ssdp_pkg::XS_TRAIL: begin
					if (div_reg > 7'h01) begin
						div_next = div_reg - 7'h01;
					end else begin
						div_next = half;
						sck_next = !sck_reg;
						st_next = ssdp_pkg::XS_LEAD;
						shift_next = lsbf ? {(clock_phase_select ? in_bit : sin_reg),
							shift_reg[7:1]} : {shift_reg[6:0],
							(clock_phase_select ? in_bit : sin_reg)};
						if (!clock_phase_select)
							dout_next = lsbf ? shift_reg[1] : shift_reg[6];
						cnt_next = cnt_reg + 4'h1;
						if (cnt_reg == 4'h7) begin
							finish = 1'b1;
							st_next = ssdp_pkg::XS_IDLE;
						end
					end
				end
				default: st_next = ssdp_pkg::XS_IDLE;
			endcase
		end else begin
			// slave: external clock, limited to a quarter of pclk
			sck_next = clock_polarity_select;
			if (!slave_sel) begin
				st_next = ssdp_pkg::XS_IDLE;
				cnt_next = 4'h0;
				if (data_wr && !busy)
					shift_next = pwdata[7:0];
				dout_next = lsbf ? shift_next[0] : shift_next[7];
			end else begin
				if (!busy)
					st_next = ssdp_pkg::XS_LEAD;
				if (s_lead) begin
					if (clock_phase_select)
						dout_next = out_bit;
					else
						sin_next = in_bit;
				end
				if (s_trail) begin
					shift_next = lsbf ? {(clock_phase_select ? in_bit : sin_reg),
						shift_reg[7:1]} : {shift_reg[6:0],
						(clock_phase_select ? in_bit : sin_reg)};
					if (!clock_phase_select)
						dout_next = lsbf ? shift_reg[1] : shift_reg[6];
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == 4'h7) begin
						finish = 1'b1;
						cnt_next = 4'h0;
					end
				end
			end
		end
		if (finish)
			rxbuf_next = shift_next;
	end

	// ==========================================
	// flags and registers
	logic vec_ack;
	assign vec_ack = wr && (paddr == ssdp_pkg::OFS_VECTOR_ACK);
	always_comb begin
		ctl_next = ctl_reg;
		dbl_next = dbl_reg;
		mask_next = mask_reg;
		done_next = done_reg;
		write_collision_flag_next = write_collision_flag_reg;
		armed_next = armed_reg;
		if (ctl_wr)
			ctl_next = pwdata[7:0];
		if (wr && paddr == ssdp_pkg::OFS_STATUS)
			dbl_next = pwdata[ssdp_pkg::STAT_DBL_BIT];
		if (wr && paddr == ssdp_pkg::OFS_IRQ_MASK)
			mask_next = pwdata[2:0];
		if (stat_rd && (done_reg || write_collision_flag_reg))
			armed_next = 1'b1;
		if (data_acc && armed_reg) begin
			done_next = 1'b0;
			write_collision_flag_next = 1'b0;
			armed_next = 1'b0;
		end
		if (vec_ack)
			done_next = 1'b0;
		// sets win over clears
		if (finish || modf)
			done_next = 1'b1;
		if (data_wr && busy)
			write_collision_flag_next = 1'b1;
		irqs_next = irqs_reg;
		if (wr && paddr == ssdp_pkg::OFS_IRQ_STATUS)
			irqs_next = irqs_reg & ~pwdata[2:0];
		if (finish)
			irqs_next[ssdp_pkg::IRQ_DONE_BIT] = 1'b1;
		if (data_wr && busy)
			irqs_next[ssdp_pkg::IRQ_WRITE_COLLISION_FLAG_BIT] = 1'b1;
		if (modf)
			irqs_next[ssdp_pkg::IRQ_MODF_BIT] = 1'b1;
		prdata_next = 32'h0;
		if (rd) begin
			case (paddr)
				ssdp_pkg::OFS_CONTROL: prdata_next = {24'h0, ctl_reg};
				// reserved status bits read zero
				ssdp_pkg::OFS_STATUS: prdata_next = {24'h0, done_reg,
					write_collision_flag_reg, 5'h00, dbl_reg};
				ssdp_pkg::OFS_DATA: prdata_next = {24'h0, rxbuf_next};
				ssdp_pkg::OFS_IRQ_STATUS: prdata_next = {29'h0, irqs_reg};
				ssdp_pkg::OFS_IRQ_MASK: prdata_next = {29'h0, mask_reg};
				default: prdata_next = 32'h0;
			endcase
		end
	end
	assign prdata = (rd && paddr == ssdp_pkg::OFS_DATA) ?
		{24'h0, rxbuf_reg} : prdata_comb(rd, prdata_next);
	function automatic logic [31:0] prdata_comb(input logic r,
		input logic [31:0] v);
		prdata_comb = r ? v : 32'h0;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_reg <= ssdp_pkg::CONTROL_RESET;
			dbl_reg <= 1'b0;
			done_reg <= 1'b0;
			write_collision_flag_reg <= 1'b0;
			armed_reg <= 1'b0;
			irqs_reg <= ssdp_pkg::IRQ_RESET;
			mask_reg <= ssdp_pkg::IRQ_RESET;
			st_reg <= ssdp_pkg::XS_IDLE;
			shift_reg <= 8'h00;
			rxbuf_reg <= 8'h00;
			cnt_reg <= 4'h0;
			div_reg <= 7'h00;
			sck_reg <= 1'b0;
			dout_reg <= 1'b0;
			sin_reg <= 1'b0;
		end else begin
			ctl_reg <= ctl_next;
			dbl_reg <= dbl_next;
			done_reg <= done_next;
			write_collision_flag_reg <= write_collision_flag_next;
			armed_reg <= armed_next;
			irqs_reg <= irqs_next;
			mask_reg <= mask_next;
			st_reg <= st_next;
			shift_reg <= shift_next;
			rxbuf_reg <= rxbuf_next;
			cnt_reg <= cnt_next;
			div_reg <= div_next;
			sck_reg <= sck_next;
			dout_reg <= dout_next;
			sin_reg <= sin_next;
		end
	end

	// ==========================================
	// outputs
	assign irq = (|(irqs_reg & mask_reg)) || (done_reg && global_irq_enable
		&& ctl_reg[ssdp_pkg::CTL_IRQ_EN_BIT]);
	assign sck_out = sck_reg;
	assign sck_oe = en && master && !modf;
	assign mosi_out = dout_reg;
	assign mosi_oe = en && master && !modf;
	assign miso_out = dout_reg;
	assign miso_oe = slave_sel;

	// ==========================================
	// assertions
	a_done_on_finish: assert property (@(posedge pclk) disable iff (!presetn)
		finish |=> done_reg) else $error("done flag not set");
	a_irq_follows_done: assert property (@(posedge pclk)
		disable iff (!presetn) (done_reg && global_irq_enable &&
		ctl_reg[ssdp_pkg::CTL_IRQ_EN_BIT]) |-> irq)
		else $error("irq missing");
	a_modf_sets_done: assert property (@(posedge pclk) disable iff (!presetn)
		modf |=> done_reg) else $error("select low no flag");
	a_vector_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(vec_ack && !finish && !modf) |=> !done_reg)
		else $error("vector ack no clear");
	a_seq_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(data_acc && armed_reg && !finish && !modf && !(data_wr && busy))
		|=> !done_reg && !write_collision_flag_reg) else $error("clear seq failed");
	a_write_collision_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
		(data_wr && busy) |=> write_collision_flag_reg) else $error("no collision");
	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == ssdp_pkg::OFS_STATUS) |-> prdata[5:1] == 5'h00)
		else $error("reserved bits nonzero");
	a_write_collision_flag_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		(data_wr && busy && master && div_reg > 7'h01) |=>
		shift_reg == $past(shift_reg)) else $error("shift disturbed");
	a_dbl_min: assert property (@(posedge pclk) disable iff (!presetn)
		(master && busy && $changed(sck_reg)) |-> div_reg == half &&
		half != 7'h00) else $error("sck too fast");
	a_start_xfer: assert property (@(posedge pclk) disable iff (!presetn)
		(data_wr && !busy && en && master && !modf) |=>
		st_reg == ssdp_pkg::XS_LEAD) else $error("no start");
	c_master_done: cover property (@(posedge pclk) finish && master);
	c_slave_done: cover property (@(posedge pclk) finish && !master);
	c_collision: cover property (@(posedge pclk) data_wr && busy);
	c_modf: cover property (@(posedge pclk) modf);

endmodule // ssdp_core

// File: testbench/ssdp_partner.sv
// far side serial device: slave during master runs, master on demand
`timescale 1ns/1ns
module ssdp_partner (
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	output logic p_sck,
	output logic p_mosi,
	output logic p_miso,
	output logic p_ss_n
);
	logic clock_polarity_select;
	logic clock_phase_select;
	logic [7:0] sr;
	logic [7:0] got;
	initial begin
		clock_polarity_select = 1'b0;
		clock_phase_select = 1'b0;
		sr = 8'h00;
		got = 8'h00;
		p_sck = 1'b0;
		p_mosi = 1'b0;
		p_miso = 1'b0;
		p_ss_n = 1'b1;
	end
	// ==========================================
	// slave: shift on one edge, sample on the other
	always @(sck) begin
		if (sck !== clock_polarity_select) begin
			if (clock_phase_select) begin
				p_miso = sr[7];
				sr = sr << 1;
			end else begin
				got = {got[6:0], mosi};
			end
		end else if (clock_phase_select) begin
			got = {got[6:0], mosi};
		end else begin
			sr = sr << 1;
			p_miso = sr[7];
		end
	end
	task automatic arm(input logic [7:0] r, input logic pol, input logic pha);
		clock_polarity_select = pol;
		clock_phase_select = pha;
		sr = r;
		got = 8'h00;
		p_miso = r[7];
	endtask
	task automatic ss_pulse();
		p_ss_n = 1'b0;
		#80 p_ss_n = 1'b1;
	endtask
	// ==========================================
	// master: mode 0, 48 ns clock, only within the frame
	task automatic mxfer(input logic [7:0] t, output logic [7:0] rx);
		#7 p_ss_n = 1'b0;
		p_mosi = t[7];
		for (int i = 7; i >= 0; i--) begin
			#24 p_sck = 1'b1;
			rx[i] = miso;
			#24 p_sck = 1'b0;
			if (i > 0) p_mosi = t[i-1];
		end
		#24 p_ss_n = 1'b1;
		p_mosi = ~p_mosi;
	endtask
endmodule // ssdp_partner

// File: testbench/spi_status_data_path_tb.sv
// testbench: apb driven checks of the serial status and data path
`timescale 1ns/1ns
module spi_status_data_path_tb;
	logic pclk, presetn, psel, penable, pwrite, gie, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d, ctl;
	logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, err;
	logic p_sck, p_mosi, p_miso, p_ss_n;
	logic [7:0] tx, rep, got;
	logic [31:0] seed = 32'h4;
	int fails = 0;
	int checks = 0;
	int txq[$];
	wire sck_w = sck_oe ? sck_out : p_sck;
	wire mosi_w = mosi_oe ? mosi_out : p_mosi;
	wire miso_w = miso_oe ? miso_out : p_miso;
	ssdp_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.global_irq_enable(gie), .irq(irq), .sck_in(sck_w),
		.sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
		.mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
		.miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(p_ss_n));
	ssdp_partner prt (.sck(sck_w), .mosi(mosi_w), .miso(miso_w),
		.p_sck(p_sck), .p_mosi(p_mosi), .p_miso(p_miso), .p_ss_n(p_ss_n));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// ==========================================
	// helpers
	function automatic logic [7:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(d, e);
	endtask
	task automatic irqc(input logic e);
		@(posedge pclk);
		#1;
		chk(irq, e);
	endtask
	task automatic wait_done();
		d = 32'h0;
		for (int n = 0; n < 500 && d[7] !== 1'b1; n++) begin
			apb(1'b0, ssdp_pkg::OFS_STATUS, 32'h0);
		end
	endtask
	task automatic mx(input logic [7:0] t, input logic [7:0] r);
		tx = t;
		rep = r;
		repeat (4) @(posedge pclk);
		prt.arm(r, ctl[3], ctl[2]);
		apb(1'b1, ssdp_pkg::OFS_DATA, {24'h0, t});
		txq.push_back(t);
	endtask
	task automatic measure(input int e);
		logic s;
		int n;
		@(posedge pclk);
		#1;
		for (int k = 0; k < 3; k++) begin
			s = sck_out;
			for (n = 0; n < 300 && sck_out === s; n++) begin
				@(posedge pclk);
				#1;
			end
		end
		chk(n, e);
	endtask
	task automatic results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ==========================================
	// sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		gie = 1'b1;
		ctl = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ssdp_pkg::OFS_CONTROL, 32'h0);
		rdc(ssdp_pkg::OFS_STATUS, 32'h0);
		rdc(ssdp_pkg::OFS_IRQ_MASK, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk(err, 1'b1);
		for (int m = 0; m < 4; m++) begin
			ctl = 32'hD1 | (m << 2);
			gie <= (m != 1);
			apb(1'b1, ssdp_pkg::OFS_CONTROL, ctl);
			mx(xs(), xs());
			chk({sck_oe, mosi_oe, miso_oe}, 3'b110);
			if (m == 0) measure(8);
			wait_done();
			chk(d, 32'h80);
			chk(irq, m != 1);
			chk(prt.got, txq.pop_front());
			rdc(ssdp_pkg::OFS_DATA, rep);
			rdc(ssdp_pkg::OFS_STATUS, 32'h0);
		end
		ctl = 32'hD1;
		gie <= 1'b1;
		apb(1'b1, ssdp_pkg::OFS_CONTROL, ctl);
		mx(xs(), xs());
		apb(1'b1, ssdp_pkg::OFS_DATA, {24'h0, ~tx});
		wait_done();
		chk(d, 32'hC0);
		chk(prt.got, txq.pop_front());
		rdc(ssdp_pkg::OFS_DATA, rep);
		rdc(ssdp_pkg::OFS_STATUS, 32'h0);
		apb(1'b1, ssdp_pkg::OFS_IRQ_STATUS, 32'h7);
		mx(xs(), xs());
		for (int n = 0; n < 500 && irq !== 1'b1; n++) @(posedge pclk);
		chk(irq, 1'b1);
		chk(prt.got, txq.pop_front());
		apb(1'b1, ssdp_pkg::OFS_VECTOR_ACK, 32'h1);
		irqc(1'b0);
		rdc(ssdp_pkg::OFS_STATUS, 32'h0);
		rdc(ssdp_pkg::OFS_IRQ_STATUS, 32'h1);
		apb(1'b1, ssdp_pkg::OFS_IRQ_MASK, 32'h1);
		irqc(1'b1);
		apb(1'b1, ssdp_pkg::OFS_IRQ_STATUS, 32'h1);
		irqc(1'b0);
		apb(1'b1, ssdp_pkg::OFS_STATUS, 32'h1);
		rdc(ssdp_pkg::OFS_STATUS, 32'h1);
		mx(xs(), xs());
		measure(4);
		wait_done();
		chk(d, 32'h81);
		chk(prt.got, txq.pop_front());
		rdc(ssdp_pkg::OFS_DATA, rep);
		apb(1'b1, ssdp_pkg::OFS_CONTROL, 32'hD0);
		mx(xs(), xs());
		measure(1);
		wait_done();
		chk(d, 32'h81);
		chk(prt.got, txq.pop_front());
		apb(1'b0, ssdp_pkg::OFS_DATA, 32'h0);
		apb(1'b1, ssdp_pkg::OFS_STATUS, 32'h0);
		prt.ss_pulse();
		rdc(ssdp_pkg::OFS_STATUS, 32'h80);
		apb(1'b0, ssdp_pkg::OFS_DATA, 32'h0);
		rdc(ssdp_pkg::OFS_STATUS, 32'h0);
		apb(1'b1, ssdp_pkg::OFS_CONTROL, 32'h40);
		tx = xs();
		rep = xs();
		apb(1'b1, ssdp_pkg::OFS_DATA, {24'h0, tx});
		chk({sck_oe, mosi_oe, miso_oe}, 3'b000);
		prt.mxfer(rep, got);
		wait_done();
		chk(d, 32'h80);
		chk(got, tx);
		rdc(ssdp_pkg::OFS_DATA, rep);
		results();
	end
	initial begin
		#100000;
		fails++;
		results();
	end
endmodule // spi_status_data_path_tb
